// >>> rtl/jbsp_map.vh
// Purpose: constants for the boundary-scan port
// Assumes: included once per design file
// Notes: instruction codes and tap state codes
`ifndef JBSP_MAP_VH
`define JBSP_MAP_VH
`define JBSP_IR_W 3
`define JBSP_IR_EXTEST 3'h0
`define JBSP_IR_USER1 3'h1
`define JBSP_IR_CFGWR 3'h2
`define JBSP_IR_IDCODE 3'h3
`define JBSP_IR_SAMPLE 3'h4
`define JBSP_IR_USER2 3'h5
`define JBSP_IR_RDBACK 3'h6
`define JBSP_IR_BYPASS 3'h7
`define JBSP_IR_CAPT 3'h1
`define JBSP_ID_VER_W 4
`define JBSP_ID_PART_W 10
`define JBSP_ID_FAM_W 6
`define JBSP_ID_MFR_W 11
`define JBSP_ID_W 32
`define JBSP_ST_W 16
`define JBSP_S_RESET 16'h0001
`define JBSP_S_IDLE 16'h0002
`define JBSP_S_SELDR 16'h0004
`define JBSP_S_CAPDR 16'h0008
`define JBSP_S_SHDR 16'h0010
`define JBSP_S_EX1DR 16'h0020
`define JBSP_S_PADR 16'h0040
`define JBSP_S_EX2DR 16'h0080
`define JBSP_S_UPDR 16'h0100
`define JBSP_S_SELIR 16'h0200
`define JBSP_S_CAPIR 16'h0400
`define JBSP_S_SHIR 16'h0800
`define JBSP_S_EX1IR 16'h1000
`define JBSP_S_PAIR 16'h2000
`define JBSP_S_EX2IR 16'h4000
`define JBSP_S_UPIR 16'h8000
`endif

// >>> rtl/jbsp_top.v
// What this block does
// - three-bit instruction register, serially loaded
// - eight instruction codes decoded as listed
// - code 001 user ring or usercode, option
// - extest: two cells per pad, drive or capture
// - sample captures pads, preload loads all update cells together
// - idcode captures 32-bit word, shifts out
// - id layout version part family maker one
// - part field is array size, reversed bits
// - bypass is a single flip-flop
// - chain runs clockwise from top-left pad
// - cells on every pad except excluded ones
// - reconfigure pin resets all scan logic except the usercode register
// - active before configuration, option afterwards
// - after reset, data shift gives idcode
// - disabled: pins freed, output tristated/readback
// - 11-bit usercode replaces maker field
// - idcode always returns true maker field
// - config write takes serial data in
// - readback shifts config data out
// - user rings connect internal chains
// - inputs sampled rising, output changes falling
// - sixteen-state controller driven by mode select
//
// Purpose: boundary-scan test access port, oversampled on clk_i
// Assumes: clk_i much faster than the test clock
// Notes: pad list is ordered clockwise; cell 0 nearest the data input
//   update registers and the instruction register load on the tck rise that leaves update
//   usercode is written by a data scan under the usercode instruction, at update
//   pin edges are ignored until the synchronisers hold real samples after reset
`include "jbsp_map.vh"
`default_nettype none
module jbsp_top #(
  // one cell pair per user pad; config clock, done and test pins carry none
  parameter NPADS = 8,
  parameter [`JBSP_ID_VER_W-1:0] ID_VERSION = 4'h0,
  // array size in natural order; arbitrary value
  parameter [`JBSP_ID_PART_W-1:0] ID_PART_SIZE = 10'h015,
  // family and maker values arbitrary
  parameter [`JBSP_ID_FAM_W-1:0] ID_FAMILY = 6'h2a,
  parameter [`JBSP_ID_MFR_W-1:0] ID_MAKER = 11'h155
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // test port pins
  input wire tck_i,
  input wire tms_i,
  input wire tdi_i,
  output reg tdo_o,
  output reg tdo_oe_o,
  // reconfigure pin, active low
  input wire reconfigure_pin_n_i,
  // configuration state and options
  input wire configured_i,
  input wire opt_scan_keep_i,
  input wire opt_usercode_i,
  input wire [`JBSP_ID_MFR_W-1:0] usercode_init_i,
  input wire usercode_load_i,
  // pads: clockwise order, index 0 first
  input wire [NPADS-1:0] pad_in_i,
  input wire [NPADS-1:0] core_out_i,
  input wire [NPADS-1:0] core_oe_i,
  output reg [NPADS-1:0] pad_out_o,
  output reg [NPADS-1:0] pad_oe_o,
  // user rings
  input wire ring1_tdo_i,
  input wire ring2_tdo_i,
  output reg ring_tdi_o,
  output reg ring1_shift_o,
  output reg ring2_shift_o,
  // configuration write and readback
  output reg cfg_wr_bit_o,
  output reg cfg_wr_valid_o,
  input wire rdback_bit_i,
  output reg rdback_next_o,
  // pins freed for user logic
  output reg scan_pins_free_o
);
  // two-flop synchronisers on the pins
  reg [2:0] s1_q;
  reg [2:0] s2_q;
  reg tck_prev_q;
  reg reconfigure_pin_n_q;
  // edges count only once tck_prev_q holds a real sample, so reset makes no false edge
  reg [2:0] sync_ok_q;
  wire rise = s2_q[0] & ~tck_prev_q & sync_ok_q[2];
  wire fall = ~s2_q[0] & tck_prev_q & sync_ok_q[2];
  wire tms = s2_q[1];
  wire tdi = s2_q[2];
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      tck_prev_q <= 1'b0;
      sync_ok_q <= 3'h0;
    end
    else
    begin
      s1_q <= {tdi_i, tms_i, tck_i};
      s2_q <= s1_q;
      tck_prev_q <= s2_q[0];
      sync_ok_q <= {sync_ok_q[1:0], 1'b1};
    end
  end
  reg pr1_q;
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pr1_q <= 1'b1;
      reconfigure_pin_n_q <= 1'b1;
    end
    else
    begin
      pr1_q <= reconfigure_pin_n_i;
      reconfigure_pin_n_q <= pr1_q;
    end
  end
  // enable: always before configuration, option afterwards
  wire scan_en = ~configured_i | opt_scan_keep_i;
  wire hold_rst = ~reconfigure_pin_n_q | ~scan_en;
  // controller
  reg [`JBSP_ST_W-1:0] st_q;
  reg [`JBSP_ST_W-1:0] st_d;
  always @*
  begin
    case (st_q)
      `JBSP_S_RESET: st_d = tms ? `JBSP_S_RESET : `JBSP_S_IDLE;
      `JBSP_S_IDLE: st_d = tms ? `JBSP_S_SELDR : `JBSP_S_IDLE;
      `JBSP_S_SELDR: st_d = tms ? `JBSP_S_SELIR : `JBSP_S_CAPDR;
      `JBSP_S_CAPDR: st_d = tms ? `JBSP_S_EX1DR : `JBSP_S_SHDR;
      `JBSP_S_SHDR: st_d = tms ? `JBSP_S_EX1DR : `JBSP_S_SHDR;
      `JBSP_S_EX1DR: st_d = tms ? `JBSP_S_UPDR : `JBSP_S_PADR;
      `JBSP_S_PADR: st_d = tms ? `JBSP_S_EX2DR : `JBSP_S_PADR;
      `JBSP_S_EX2DR: st_d = tms ? `JBSP_S_UPDR : `JBSP_S_SHDR;
      `JBSP_S_UPDR: st_d = tms ? `JBSP_S_SELDR : `JBSP_S_IDLE;
      `JBSP_S_SELIR: st_d = tms ? `JBSP_S_RESET : `JBSP_S_CAPIR;
      `JBSP_S_CAPIR: st_d = tms ? `JBSP_S_EX1IR : `JBSP_S_SHIR;
      `JBSP_S_SHIR: st_d = tms ? `JBSP_S_EX1IR : `JBSP_S_SHIR;
      `JBSP_S_EX1IR: st_d = tms ? `JBSP_S_UPIR : `JBSP_S_PAIR;
      `JBSP_S_PAIR: st_d = tms ? `JBSP_S_EX2IR : `JBSP_S_PAIR;
      `JBSP_S_EX2IR: st_d = tms ? `JBSP_S_UPIR : `JBSP_S_SHIR;
      `JBSP_S_UPIR: st_d = tms ? `JBSP_S_SELDR : `JBSP_S_IDLE;
      default: st_d = `JBSP_S_RESET;
    endcase
  end
  // registers
  reg [`JBSP_IR_W-1:0] ir_sh_q;
  reg [`JBSP_IR_W-1:0] ir_q;
  reg byp_q;
  reg [`JBSP_ID_W-1:0] id_sh_q;
  reg [`JBSP_ID_MFR_W-1:0] ucode_q;
  reg [NPADS-1:0] bo_sh_q;
  reg [NPADS-1:0] bt_sh_q;
  reg [NPADS-1:0] bo_up_q;
  reg [NPADS-1:0] bt_up_q;
  reg [NPADS-1:0] pin_q1;
  reg [NPADS-1:0] pin_q2;
  function [`JBSP_ID_PART_W-1:0] rev;
    input [`JBSP_ID_PART_W-1:0] v;
    integer i;
    begin
      for (i = 0; i < `JBSP_ID_PART_W; i = i + 1)
        rev[i] = v[`JBSP_ID_PART_W-1-i];
    end
  endfunction
  wire [`JBSP_ID_W-1:0] id_word = {ID_VERSION, rev(ID_PART_SIZE), ID_FAMILY, ID_MAKER, 1'b1};
  wire [`JBSP_ID_W-1:0] uc_word = {ID_VERSION, rev(ID_PART_SIZE), ID_FAMILY, ucode_q, 1'b1};
  // decode, with option-dependent fallback
  wire i_ext = ir_q == `JBSP_IR_EXTEST;
  wire i_smp = ir_q == `JBSP_IR_SAMPLE;
  wire i_id = ir_q == `JBSP_IR_IDCODE;
  wire i_uc = (ir_q == `JBSP_IR_USER1) & opt_usercode_i;
  wire i_r1 = (ir_q == `JBSP_IR_USER1) & ~opt_usercode_i;
  wire i_r2 = ir_q == `JBSP_IR_USER2;
  wire i_wr = ir_q == `JBSP_IR_CFGWR;
  // readback answers only on a configured device, else bypass
  wire i_rd = (ir_q == `JBSP_IR_RDBACK) & configured_i;
  wire i_bsr = i_ext | i_smp;
  wire i_idp = i_id | i_uc;
  wire i_byp = ~(i_bsr | i_idp | i_r1 | i_r2 | i_wr | i_rd);
  wire shdr = st_q == `JBSP_S_SHDR;
  wire pad_cap = i_bsr & (st_q == `JBSP_S_CAPDR);
  // extest: a pad we drive shows our own value, an undriven pad its input
  wire [NPADS-1:0] ext_cap = (bt_up_q & bo_up_q) | (~bt_up_q & pin_q2);
  // sample sees the pad itself, whoever drives it
  wire [NPADS-1:0] bo_cap = i_ext ? ext_cap : pin_q2;
  wire [NPADS-1:0] bt_cap = i_ext ? bt_up_q : core_oe_i;
  // the chain holds data and tristate cell per pad; tristate cell nearer the input
  wire [2*NPADS-1:0] chain = {bo_sh_q, bt_sh_q};
  // usercode write lands at update, from the maker field of the shifter
  wire uc_upd = rise & (st_q == `JBSP_S_UPDR) & i_uc & ~hold_rst;
  // one strobe per data shift for the side paths
  wire dr_step = rise & shdr & ~hold_rst;
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
      ucode_q <= 11'h000;
    else if (usercode_load_i)
      ucode_q <= usercode_init_i;
    else if (uc_upd)
      ucode_q <= id_sh_q[`JBSP_ID_MFR_W:1];
  end
  always @(posedge clk_i)
  begin
    if (!rst_n_i || hold_rst)
    begin
      st_q <= `JBSP_S_RESET;
      ir_sh_q <= `JBSP_IR_CAPT;
      ir_q <= `JBSP_IR_IDCODE;
      byp_q <= 1'b0;
      id_sh_q <= 32'h00000000;
      bo_sh_q <= {NPADS{1'b0}};
      bt_sh_q <= {NPADS{1'b0}};
      bo_up_q <= {NPADS{1'b0}};
      bt_up_q <= {NPADS{1'b0}};
    end
    else if (rise)
    begin
      st_q <= st_d;
      case (st_q)
        `JBSP_S_RESET: ir_q <= `JBSP_IR_IDCODE;
        `JBSP_S_CAPIR: ir_sh_q <= `JBSP_IR_CAPT;
        // ir shifter reads out lsb first
        `JBSP_S_SHIR: ir_sh_q <= {tdi, ir_sh_q[`JBSP_IR_W-1:1]};
        `JBSP_S_UPIR: ir_q <= ir_sh_q;
        `JBSP_S_CAPDR:
        begin
          // bypass flop clears on capture, so its first bit out is zero
          byp_q <= 1'b0;
          // idcode never takes the usercode, whatever it holds
          if (i_id)
            id_sh_q <= id_word;
          else if (i_uc)
            id_sh_q <= uc_word;
          if (pad_cap)
          begin
            bt_sh_q <= bt_cap;
            bo_sh_q <= bo_cap;
          end
        end
        `JBSP_S_SHDR:
        begin
          byp_q <= tdi;
          id_sh_q <= {tdi, id_sh_q[`JBSP_ID_W-1:1]};
          if (i_bsr)
          begin
            bt_sh_q <= {bt_sh_q[NPADS-2:0], tdi};
            bo_sh_q <= {bo_sh_q[NPADS-2:0], bt_sh_q[NPADS-1]};
          end
        end
        `JBSP_S_UPDR:
          if (i_bsr)
          begin
            bo_up_q <= bo_sh_q;
            bt_up_q <= bt_sh_q;
          end
        default:
          ir_q <= ir_q;
      endcase
    end
  end
  // pad inputs cross in through two flops
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pin_q1 <= {NPADS{1'b0}};
      pin_q2 <= {NPADS{1'b0}};
    end
    else
    begin
      pin_q1 <= pad_in_i;
      pin_q2 <= pin_q1;
    end
  end
  // serial output mux
  reg dr_bit;
  always @*
  begin
    dr_bit = byp_q;
    if (i_idp)
      dr_bit = id_sh_q[0];
    else if (i_bsr)
      dr_bit = chain[2*NPADS-1];
    else if (i_r1)
      dr_bit = ring1_tdo_i;
    else if (i_r2)
      dr_bit = ring2_tdo_i;
    else if (i_rd)
      dr_bit = rdback_bit_i;
  end
  wire ir_out = st_q == `JBSP_S_SHIR;
  // tdo moves on the falling edge only, so the host samples a stable level
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
      pad_out_o <= {NPADS{1'b0}};
      pad_oe_o <= {NPADS{1'b0}};
      ring_tdi_o <= 1'b0;
      ring1_shift_o <= 1'b0;
      ring2_shift_o <= 1'b0;
      cfg_wr_bit_o <= 1'b0;
      cfg_wr_valid_o <= 1'b0;
      rdback_next_o <= 1'b0;
      scan_pins_free_o <= 1'b0;
    end
    else
    begin
      scan_pins_free_o <= ~scan_en;
      ring_tdi_o <= tdi;
      ring1_shift_o <= dr_step & i_r1;
      ring2_shift_o <= dr_step & i_r2;
      cfg_wr_bit_o <= tdi;
      cfg_wr_valid_o <= dr_step & i_wr;
      rdback_next_o <= dr_step & i_rd;
      // pads follow the core while scan is held in reset
      if (hold_rst)
      begin
        tdo_oe_o <= 1'b0;
        pad_out_o <= core_out_i;
        pad_oe_o <= core_oe_i;
      end
      else if (fall)
      begin
        tdo_oe_o <= ir_out | shdr;
        tdo_o <= ir_out ? ir_sh_q[0] : dr_bit;
        // extest drives the pads on the tck fall, like tdo
        pad_out_o <= i_ext ? bo_up_q : core_out_i;
        pad_oe_o <= i_ext ? bt_up_q : core_oe_i;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/jbsp_chk.sv
// Purpose: port checks for the scan port
// Assumes: one clock domain, clk_i
// Notes: bound into jbsp_top
`default_nettype none
module jbsp_chk #(
  parameter NPADS = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // watched ports
  input wire logic tdo_oe_o,
  input wire logic reconfigure_pin_n_i,
  input wire logic configured_i,
  input wire logic opt_scan_keep_i,
  input wire logic [NPADS-1:0] core_out_i,
  input wire logic [NPADS-1:0] pad_out_o,
  input wire logic ring1_shift_o,
  input wire logic ring2_shift_o,
  input wire logic cfg_wr_valid_o,
  input wire logic rdback_next_o,
  input wire logic scan_pins_free_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // long enough for the two-flop sync and the tap reset
  sequence s_hold;
    !reconfigure_pin_n_i [*6];
  endsequence
  property p_rcfg;
    s_hold |-> !tdo_oe_o;
  endproperty
  a_rcfg: assert property (p_rcfg) else $error("tdo driven in reconfigure");
  property p_core;
    (!reconfigure_pin_n_i && $stable(core_out_i)) [*8] |-> pad_out_o == core_out_i;
  endproperty
  a_core: assert property (p_core) else $error("pads not from core");
  property p_free;
    (configured_i && !opt_scan_keep_i) [*6] |-> scan_pins_free_o;
  endproperty
  a_free: assert property (p_free) else $error("pins not freed");
  property p_free_oe;
    scan_pins_free_o |-> !tdo_oe_o;
  endproperty
  a_free_oe: assert property (p_free_oe) else $error("tdo driven when free");
  property p_noconf;
    !configured_i [*4] |-> !scan_pins_free_o;
  endproperty
  a_noconf: assert property (p_noconf) else $error("freed before config");
  property p_wr;
    cfg_wr_valid_o |=> !cfg_wr_valid_o;
  endproperty
  a_wr: assert property (p_wr) else $error("write pulse too long");
  property p_excl;
    ring1_shift_o |-> !ring2_shift_o && !cfg_wr_valid_o && !rdback_next_o;
  endproperty
  a_excl: assert property (p_excl) else $error("two paths shifting");
  property p_rdb;
    rdback_next_o |-> configured_i && !scan_pins_free_o;
  endproperty
  a_rdb: assert property (p_rdb) else $error("readback unconfigured");
endmodule
bind jbsp_top jbsp_chk #(.NPADS(NPADS)) jbsp_chk_i (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .tdo_oe_o(tdo_oe_o), .reconfigure_pin_n_i(reconfigure_pin_n_i),
  .configured_i(configured_i), .opt_scan_keep_i(opt_scan_keep_i), .core_out_i(core_out_i),
  .pad_out_o(pad_out_o), .ring1_shift_o(ring1_shift_o), .ring2_shift_o(ring2_shift_o),
  .cfg_wr_valid_o(cfg_wr_valid_o), .rdback_next_o(rdback_next_o), .scan_pins_free_o(scan_pins_free_o));
`default_nettype wire

// >>> verification/jbsp_host.sv
// Purpose: test host stepping the scan port
// Assumes: tasks entered at a clk_i rise
// Notes: tck period 8 clk, stands high between scans
`default_nettype none
module jbsp_host (
  // system clock
  input wire logic clk_i,
  // test port
  input wire logic tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    tck_o = 1;
    tms_o = 1;
    tdi_o = 0;
  end
  // tdo read late in the cycle, well after it settles
  task automatic step(input logic m, input logic d, output logic o);
    tck_o <= 0;
    tms_o <= m;
    tdi_o <= d;
    repeat (4) @(posedge clk_i);
    tck_o <= 1;
    repeat (4) @(posedge clk_i);
    o = tdo_i;
  endtask
  task automatic tlr;
    logic o;
    repeat (5) step(1, 0, o);
    step(0, 0, o);
  endtask
  task automatic scan(input logic ir, input int n, input logic [31:0] d, output logic [31:0] q);
    logic o;
    q = 0;
    step(1, 0, o);
    if (ir) step(1, 0, o);
    step(0, 0, o);
    step(0, 0, o);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, d[i], o);
      q[i] = o;
    end
    step(1, 0, o);
    step(0, 0, o);
  endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Purpose: self-checking bench for the scan port
// Assumes: host model drives the test pins
// Notes: id field values arbitrary
`include "jbsp_map.vh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [3:0] VER = 4'h3;
  localparam [9:0] PART = 10'h0c1;
  localparam [5:0] FAM = 6'h15;
  localparam [10:0] MFR = 11'h2a7;
  logic clk_i = 0, rst_n_i = 0, rcfg_n = 1, conf = 0, keep = 0, optuc = 0, ucld = 0;
  logic r1 = 1, r2 = 0, rdb = 1;
  logic [10:0] ucv = 11'h4d3;
  logic [7:0] pin = 8'h3b, cout = 8'h0f, coe = 8'hc3;
  wire tck, tms, tdi, tdo, oe, r1s, r2s, wrv, rdn, free, rtdi, wbit;
  wire [7:0] pout, poe;
  // tdo has a pull-up on the board, so a released pin reads high
  wire tdo_pin = oe ? tdo : 1'b1;
  logic [7:0] wbits = 0, rbits = 0;
  int num_errors = 0, checks_done = 0, cyc = 0, pulses = 0;
  logic [31:0] q, id;
  jbsp_top #(.NPADS(8), .ID_VERSION(VER), .ID_PART_SIZE(PART), .ID_FAMILY(FAM), .ID_MAKER(MFR)) jbsp_top_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(oe),
    .reconfigure_pin_n_i(rcfg_n), .configured_i(conf), .opt_scan_keep_i(keep), .opt_usercode_i(optuc),
    .usercode_init_i(ucv), .usercode_load_i(ucld), .pad_in_i(pin), .core_out_i(cout), .core_oe_i(coe),
    .pad_out_o(pout), .pad_oe_o(poe), .ring1_tdo_i(r1), .ring2_tdo_i(r2), .ring_tdi_o(rtdi), .ring1_shift_o(r1s),
    .ring2_shift_o(r2s), .cfg_wr_bit_o(wbit), .cfg_wr_valid_o(wrv), .rdback_bit_i(rdb), .rdback_next_o(rdn),
    .scan_pins_free_o(free));
  jbsp_host jbsp_host_i (.clk_i(clk_i), .tdo_i(tdo_pin), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    pulses <= pulses + (r1s | r2s | wrv | rdn);
    if (wrv)
      wbits <= {wbit, wbits[7:1]};
    if (r1s | r2s)
      rbits <= {rtdi, rbits[7:1]};
    if (cyc == 30000)
    begin
      num_errors++;
      test_done;
    end
  end
  function automatic logic [31:0] rv(input logic [31:0] v, input int w);
    rv = 0;
    for (int i = 0; i < w; i++) rv[i] = v[w-1-i];
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      num_errors++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done;
    if (num_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic ir(input logic [2:0] c);
    jbsp_host_i.scan(1, 3, c, q);
  endtask
  task automatic dr(input int n, input logic [31:0] d);
    jbsp_host_i.scan(0, n, d, q);
  endtask
  task automatic t_id;
    jbsp_host_i.tlr;
    dr(32, 0);
    chk("idcode", q, id);
  endtask
  task automatic t_byp;
    ir(`JBSP_IR_BYPASS);
    chk("ir capture", q, `JBSP_IR_CAPT);
    dr(8, 8'hb4);
    chk("bypass", q, 8'h68);
  endtask
  task automatic t_bs;
    logic o;
    logic [15:0] pre;
    pre = 16'(rv(16'h9c36, 16));
    ir(`JBSP_IR_SAMPLE);
    dr(16, 16'h9c36);
    chk("sample", q, rv({pin, coe}, 16));
    ir(`JBSP_IR_EXTEST);
    jbsp_host_i.step(0, 0, o);
    chk("preload", {pout, poe}, rv(16'h9c36, 16));
    dr(16, 16'h35e1);
    chk("extest capture", q, rv({(pre[15:8] & pre[7:0]) | (~pre[7:0] & pin), pre[7:0]}, 16));
    jbsp_host_i.step(0, 0, o);
    chk("extest", {pout, poe}, rv(16'h35e1, 16));
  endtask
  task automatic t_uc;
    optuc <= 1;
    ucld <= 1;
    @(posedge clk_i) ucld <= 0;
    ir(`JBSP_IR_USER1);
    dr(32, 0);
    chk("usercode", q, {id[31:12], ucv, 1'b1});
    dr(32, {20'h00000, 11'h1e5, 1'b1});
    chk("usercode cleared", q, {id[31:12], 11'h000, 1'b1});
    dr(32, 0);
    chk("usercode written", q, {id[31:12], 11'h1e5, 1'b1});
    ir(`JBSP_IR_IDCODE);
    dr(32, 0);
    chk("id maker", q, id);
  endtask
  // a loaded instruction must not survive the reconfigure pin
  task automatic t_rst;
    logic o;
    ir(`JBSP_IR_BYPASS);
    rcfg_n <= 0;
    repeat (12) @(posedge clk_i);
    rcfg_n <= 1;
    repeat (4) @(posedge clk_i);
    jbsp_host_i.step(0, 0, o);
    dr(32, 0);
    chk("reset id", q, id);
  endtask
  task automatic t_ring;
    logic [2:0] c[4] = '{`JBSP_IR_USER1, `JBSP_IR_USER2, `JBSP_IR_RDBACK, `JBSP_IR_CFGWR};
    int b;
    logic [7:0] d;
    optuc <= 0;
    conf <= 1;
    keep <= 1;
    for (int i = 0; i < 4; i++)
    begin
      ir(c[i]);
      b = pulses;
      d = 8'h5a ^ 8'(i * 17);
      dr(8, d);
      chk("pulses", pulses - b, 8);
      if (i < 3) chk("ring data", q, (i == 1) ? 8'h00 : 8'hff);
      if (i != 2) chk("bits in", (i == 3) ? wbits : rbits, d);
    end
  endtask
  task automatic t_off;
    chk("pins held", free, 0);
    keep <= 0;
    repeat (8) @(posedge clk_i);
    chk("pins free", {free, oe}, 2'h2);
  endtask
  initial
  begin
    id = {VER, 10'h000, FAM, MFR, 1'b1} | (rv(PART, 10) << 18);
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1;
    repeat (4) @(posedge clk_i);
    t_id;
    t_byp;
    t_bs;
    t_uc;
    t_rst;
    t_ring;
    t_off;
    test_done;
  end
endmodule
`default_nettype wire
